// [smbus_pkg.sv]
// Purpose: Shared constants and types for the supply management port ends
// Assumes: 100 MHz system clock, bus clock up to 100 kHz
// Notes:   Byte addresses on the wire are the 7-bit values shifted left once
package smbus_pkg;
  localparam int         CLK_HZ          = 100_000_000;
  localparam logic [6:0] CTRL_ADDR7      = 7'h10;   // 0x20 on the wire
  localparam logic [6:0] STORE_ADDR7     = 7'h50;   // 0xA0 on the wire
  localparam int         STORE_BYTES     = 2048;
  localparam int         STORE_AW        = 11;
  localparam int         BLOCK_MAX       = 255;
  localparam int         SCL_KHZ         = 100;
  localparam int         BIT_CYC         = CLK_HZ / (SCL_KHZ * 1000);
  localparam int         QTR_CYC         = BIT_CYC / 4;
  localparam int         STRETCH_MAX_US  = 1000;
  localparam int         STRETCH_MAX_CYC = STRETCH_MAX_US * (CLK_HZ / 1_000_000);
  localparam int         STRETCH_CYC     = 16;      // Well below STRETCH_MAX_CYC
  localparam int         LOW_TMO_MS      = 25;
  localparam int         LOW_TMO_CYC     = LOW_TMO_MS * (CLK_HZ / 1000) + 1;
  localparam int         WR_CYCLE_MS     = 5;
  localparam int         WR_CYCLE_CYC    = WR_CYCLE_MS * (CLK_HZ / 1000);
  localparam int         BUF_NS          = 4700;
  localparam int         BUF_CYC         = (BUF_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  typedef enum logic [2:0] {D_IDLE, D_ADDR, D_RX, D_TX, D_IGNORE} dstate_e;
  typedef enum logic [2:0] {H_IDLE, H_START, H_BIT, H_STOP, H_GAP} hstate_e;
  typedef enum logic [2:0] {S_AW, S_CMD, S_WR, S_AR, S_RD} seg_e;
endpackage : smbus_pkg

// [smbus_if.sv]
// Purpose: Shared clock and data wires between host end and supply end
// Assumes: Open-drain lines with pull-up; each end drives low only
// Notes:   Output enables are active low
`timescale 1ns/1ps
interface smbus_if;
  logic bus_clk;
  logic bus_dat;
  logic h_clk_out;
  logic h_clk_oe_n;
  logic h_dat_out;
  logic h_dat_oe_n;
  logic d_clk_out;
  logic d_clk_oe_n;
  logic d_dat_out;
  logic d_dat_oe_n;

  // Wired-AND of both ends, released lines read high
  assign bus_clk = !((!h_clk_oe_n && !h_clk_out) || (!d_clk_oe_n && !d_clk_out));
  assign bus_dat = !((!h_dat_oe_n && !h_dat_out) || (!d_dat_oe_n && !d_dat_out));

  modport host (input bus_clk, input bus_dat,
                output h_clk_out, output h_clk_oe_n, output h_dat_out, output h_dat_oe_n);
  modport dev  (input bus_clk, input bus_dat,
                output d_clk_out, output d_clk_oe_n, output d_dat_out, output d_dat_oe_n);
endinterface : smbus_if

// [supply_port.sv]
// Purpose: Supply end: command controller target plus user storage target
// Assumes: Host is the only initiator; wp_in is an asynchronous pin
// Notes:   Storage read data is taken combinationally from the array
//
// Summary of operation
// R1 - Controller answers only fixed address 0x20
// R2 - Storage answers only fixed address 0xA0
// R3 - Both targets share one clock/data pair
// R4 - Write-lock high rejects storage writes
// R5 - Storage holds 2k user bytes, untouched
// R6 - Host storage write: address, location, data, stop
// R7 - Host waits 5 ms after storage write
// R8 - Storage read: location, restart, read address
// R9 - Host prefers single-byte storage transfers
// R10 - Clock stretch released within 1 ms
// R11 - Clock low over 25 ms aborts transfer
// R12 - Start/stop detected anywhere, resynchronise
// R13 - First byte is a command code
// R14 - Command write ends after 0, 1, 2 bytes
// R15 - Block writes up to 255 bytes accepted
// R16 - Command read returns byte or word
// R17 - Block reads up to 255 bytes served
// R18 - Target only, never starts a transfer
// R19 - Unconnected write-lock reads as high
// R20 - Locked write leaves contents unchanged
`timescale 1ns/1ps
module supply_port
  import smbus_pkg::*;
#(
  parameter int LOW_TMO = LOW_TMO_CYC,
  parameter int WR_BUSY = WR_CYCLE_CYC
) (
  // Clock and reset
  input  wire logic       mclk_in,
  input  wire logic       rst_n_in,
  // Bus pins
  smbus_if.dev            bus,
  // Storage write lock pin
  input  wire logic       wp_in,
  // Command controller side
  output logic [7:0]      cmd_out,
  output logic            cmd_stb_out,
  output logic [7:0]      wdata_out,
  output logic            wdata_stb_out,
  output logic [7:0]      wcnt_out,
  output logic            xfer_end_out,
  output logic            rd_req_out,
  output logic [7:0]      rd_idx_out,
  input  wire logic [7:0] rdata_in
);
  localparam int TW = $clog2(LOW_TMO + 1);
  localparam int BW = $clog2(WR_BUSY + 1);
  localparam int SW = $clog2(STRETCH_CYC + 1);

  typedef struct packed {
    dstate_e             st;
    logic [3:0]          ph;
    logic [7:0]          sh;
    logic                tgt_mem;
    logic                rd;
    logic                first;
    logic                act;
    logic                ackq;
    logic                hack;
    logic [STORE_AW-1:0] loc;
    logic [8:0]          cnt;
    logic                sda_drv;
    logic [SW-1:0]       str;
    logic [TW-1:0]       tmo;
    logic [BW-1:0]       busy;
    logic                wrote;
    logic [7:0]          txb;
    logic                cmd_stb;
    logic [7:0]          cmd;
    logic                wstb;
    logic [7:0]          wdat;
    logic                endp;
    logic [7:0]          wcnt;
    logic                rdreq;
    logic [7:0]          rdidx;
  } dev_s;

  dev_s                s_r;
  dev_s                s_nxt;
  logic [2:0]          scl_q;
  logic [2:0]          sda_q;
  logic [1:0]          wp_q;
  logic                scl_s;
  logic                sda_s;
  logic                wp_s;
  logic                start_det;
  logic                stop_det;
  logic                scl_rise;
  logic                scl_fall;
  logic                tmo_hit;
  logic [7:0]          b;
  logic [7:0]          tx_src;
  logic                mem_we;
  logic [7:0]          mem [STORE_BYTES];  // [R5]

  // Pins pass two flops; edges compare second and third stage only
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
      wp_q  <= 2'h3;  // Locked until the pin has been sampled [R19]
    end else begin
      scl_q <= {scl_q[1:0], bus.bus_clk};  // [R3]
      sda_q <= {sda_q[1:0], bus.bus_dat};
      wp_q  <= {wp_q[0], wp_in};
    end
  end

  assign scl_s     = scl_q[1];
  assign sda_s     = sda_q[1];
  assign wp_s      = wp_q[1];
  assign start_det = scl_s && scl_q[2] && sda_q[2] && !sda_s;  // [R12]
  assign stop_det  = scl_s && scl_q[2] && !sda_q[2] && sda_s;  // [R12]
  assign scl_rise  = scl_s && !scl_q[2];
  assign scl_fall  = !scl_s && scl_q[2];
  assign tmo_hit   = s_r.tmo >= TW'(LOW_TMO);                   // [R11]
  assign b         = {s_r.sh[6:0], sda_s};
  // Past the block limit the controller has nothing left, so ones are sent
  assign tx_src    = s_r.tgt_mem ? mem[s_r.loc] :
                     ((s_r.cnt > 9'(BLOCK_MAX)) ? 8'hFF : rdata_in);  // [R17]

  always_comb begin
    s_nxt         = s_r;
    mem_we        = 1'b0;
    s_nxt.cmd_stb = 1'b0;
    s_nxt.wstb    = 1'b0;
    s_nxt.endp    = 1'b0;
    s_nxt.rdreq   = 1'b0;
    if (scl_s) begin
      s_nxt.tmo = '0;
    end else if (!tmo_hit) begin
      s_nxt.tmo = s_r.tmo + 1'b1;
    end
    if (s_r.busy != '0) begin
      s_nxt.busy = s_r.busy - 1'b1;
    end
    // Short stretch gives the controller time to supply read data
    if (s_r.str != '0) begin
      s_nxt.str = s_r.str - 1'b1;  // [R10]
      if (s_r.str == SW'(1)) begin
        s_nxt.txb     = tx_src << 1;
        s_nxt.sda_drv = !tx_src[7];
        if (s_r.tgt_mem) begin
          s_nxt.loc = s_r.loc + 1'b1;
        end
      end
    end
    if (start_det || stop_det || tmo_hit) begin
      s_nxt.endp    = s_r.act;
      s_nxt.wcnt    = s_r.cnt[7:0];
      s_nxt.act     = 1'b0;
      s_nxt.ph      = '0;
      s_nxt.sda_drv = 1'b0;  // [R11]
      s_nxt.str     = '0;
      s_nxt.st      = start_det ? D_ADDR : D_IDLE;  // [R12]
      if (s_r.wrote) begin
        s_nxt.busy  = BW'(WR_BUSY);  // [R7]
        s_nxt.wrote = 1'b0;
      end
    end else if (s_r.st != D_IDLE && s_r.st != D_IGNORE) begin
      if (scl_rise) begin
        s_nxt.ph = s_r.ph + 1'b1;
        if (s_r.st != D_TX && s_r.ph < 4'd8) begin
          s_nxt.sh = b;
        end
        if (s_r.st != D_TX && s_r.ph == 4'd7) begin
          s_nxt.ackq = 1'b0;
          if (s_r.st == D_ADDR) begin
            s_nxt.rd    = sda_s;
            s_nxt.first = 1'b1;
            s_nxt.cnt   = '0;
            if (b[7:1] == CTRL_ADDR7) begin  // [R1]
              s_nxt.ackq    = 1'b1;
              s_nxt.tgt_mem = 1'b0;
              s_nxt.act     = 1'b1;
            end else if (b[7:1] == STORE_ADDR7 && s_r.busy == '0) begin  // [R2]
              s_nxt.ackq    = 1'b1;
              s_nxt.tgt_mem = 1'b1;
            end
          end else begin
            s_nxt.first = 1'b0;
            if (s_r.first) begin
              s_nxt.ackq = 1'b1;
              if (s_r.tgt_mem) begin
                s_nxt.loc = {{(STORE_AW-8){1'b0}}, b};  // [R8]
              end else begin
                s_nxt.cmd     = b;  // [R13]
                s_nxt.cmd_stb = 1'b1;
              end
            end else if (s_r.tgt_mem) begin
              // Locked: refuse the byte and leave the array alone
              if (!wp_s) begin  // [R4] [R20]
                s_nxt.ackq  = 1'b1;
                mem_we      = 1'b1;
                s_nxt.wrote = 1'b1;
                s_nxt.loc   = s_r.loc + 1'b1;
              end
            end else if (s_r.cnt < 9'(BLOCK_MAX)) begin  // [R14] [R15]
              s_nxt.ackq = 1'b1;
              s_nxt.wstb = 1'b1;
              s_nxt.wdat = b;
              s_nxt.cnt  = s_r.cnt + 1'b1;
            end
          end
        end
        if (s_r.st == D_TX && s_r.ph == 4'd8) begin
          s_nxt.hack = !sda_s;
        end
      end else if (scl_fall) begin
        if (s_r.ph == 4'd8) begin
          s_nxt.sda_drv = (s_r.st == D_TX) ? 1'b0 : s_r.ackq;
        end else if (s_r.ph == 4'd9) begin
          s_nxt.ph      = '0;
          s_nxt.sda_drv = 1'b0;
          if ((s_r.st == D_TX) ? !s_r.hack : !s_r.ackq) begin
            s_nxt.st = D_IGNORE;
          end else if (s_r.st == D_TX || (s_r.st == D_ADDR && s_r.rd)) begin
            s_nxt.st  = D_TX;  // [R16]
            s_nxt.str = SW'(STRETCH_CYC);  // [R10]
            if (!s_r.tgt_mem) begin
              s_nxt.rdreq = 1'b1;
              s_nxt.rdidx = s_r.cnt[7:0];
              if (s_r.cnt != 9'h100) begin
                s_nxt.cnt = s_r.cnt + 1'b1;
              end
            end
          end else begin
            s_nxt.st = D_RX;
          end
        end else if (s_r.st == D_TX && s_r.ph != 4'd0) begin
          s_nxt.sda_drv = !s_r.txb[7];
          s_nxt.txb     = s_r.txb << 1;
        end
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Array only written by bus traffic, never by supply logic
  always_ff @(posedge mclk_in) begin
    if (mem_we) begin
      mem[s_r.loc] <= b;  // [R5]
    end
  end

  // Lines are only pulled low inside an addressed transfer [R18]
  assign bus.d_clk_out  = 1'b0;
  assign bus.d_dat_out  = 1'b0;
  assign bus.d_clk_oe_n = (s_r.str == '0);
  assign bus.d_dat_oe_n = !s_r.sda_drv;
  assign cmd_out        = s_r.cmd;
  assign cmd_stb_out    = s_r.cmd_stb;
  assign wdata_out      = s_r.wdat;
  assign wdata_stb_out  = s_r.wstb;
  assign wcnt_out       = s_r.wcnt;
  assign xfer_end_out   = s_r.endp;
  assign rd_req_out     = s_r.rdreq;
  assign rd_idx_out     = s_r.rdidx;
endmodule : supply_port

// [mgmt_host.sv]
// Purpose: Host end: sole initiator of command and storage transfers
// Assumes: 100 kHz bus clock made from mclk_in by division
// Notes:   A stretched clock simply lengthens the high-wait quarter
`timescale 1ns/1ps
module mgmt_host
  import smbus_pkg::*;
#(
  parameter int WR_GAP = WR_CYCLE_CYC
) (
  // Clock and reset
  input  wire logic       mclk_in,
  input  wire logic       rst_n_in,
  // Bus pins
  smbus_if.host           bus,
  // Request
  input  wire logic       req_valid_in,
  output logic            req_ready_out,
  input  wire logic [6:0] req_addr7_in,
  input  wire logic [7:0] req_cmd_in,
  input  wire logic [7:0] req_wlen_in,
  input  wire logic [7:0] req_rlen_in,
  // Write bytes
  input  wire logic [7:0] wbyte_in,
  output logic            wbyte_take_out,
  // Read bytes and completion
  output logic [7:0]      rbyte_out,
  output logic            rbyte_valid_out,
  output logic            done_out,
  output logic            nack_out
);
  localparam int GW = $clog2(WR_GAP + 1);
  localparam int KW = $clog2(2 * QTR_CYC + 1);

  typedef struct packed {
    hstate_e     st;
    seg_e        seg;
    logic [1:0]  q;
    logic [KW-1:0] tick;
    logic [3:0]  bitn;
    logic [8:0]  tx;
    logic [8:0]  rx;
    logic        scl_lo;
    logic        sda_lo;
    logic [6:0]  addr;
    logic [7:0]  cmd;
    logic [7:0]  wl;
    logic [7:0]  rl;
    logic        rs;
    logic [GW-1:0] gap;
    logic        take;
    logic        rv;
    logic [7:0]  rbyte;
    logic        done;
    logic        nack;
  } host_s;

  host_s      s_r;
  host_s      s_nxt;
  logic [1:0] scl_q;
  logic [1:0] sda_q;
  logic       adv;
  logic [KW-1:0] qlen;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scl_q <= 2'h3;
      sda_q <= 2'h3;
    end else begin
      scl_q <= {scl_q[0], bus.bus_clk};
      sda_q <= {sda_q[0], bus.bus_dat};
    end
  end

  // Start and stop quarters are doubled to meet setup and hold times
  assign qlen = (s_r.st == H_BIT) ? KW'(QTR_CYC - 1) : KW'(2 * QTR_CYC - 1);
  assign adv  = (s_r.tick >= qlen) && (s_r.q != 2'd2 || scl_q[1]);

  always_comb begin
    s_nxt      = s_r;
    s_nxt.take = 1'b0;
    s_nxt.rv   = 1'b0;
    s_nxt.done = 1'b0;
    s_nxt.tick = adv ? '0 : s_r.tick + 1'b1;
    if (adv) begin
      s_nxt.q = s_r.q + 1'b1;
    end
    case (s_r.st)
      H_IDLE: begin
        s_nxt.tick = '0;
        s_nxt.q    = '0;
        if (req_valid_in) begin
          s_nxt.addr = req_addr7_in;
          s_nxt.cmd  = req_cmd_in;
          s_nxt.wl   = req_wlen_in;
          s_nxt.rl   = req_rlen_in;
          s_nxt.rs   = 1'b0;
          s_nxt.nack = 1'b0;
          s_nxt.st   = H_START;
          s_nxt.gap  = (req_addr7_in == STORE_ADDR7 && req_wlen_in != 8'h00) ?
                       GW'(WR_GAP) : GW'(BUF_CYC);  // [R7]
        end
      end
      H_START: if (adv) begin
        case (s_r.q)
          2'd0: s_nxt.sda_lo = 1'b0;
          2'd1: s_nxt.scl_lo = 1'b0;
          2'd2: s_nxt.sda_lo = 1'b1;
          default: begin
            s_nxt.scl_lo = 1'b1;
            s_nxt.st     = H_BIT;
            s_nxt.bitn   = '0;
            s_nxt.seg    = s_r.rs ? S_AR : S_AW;  // [R8] [R16]
            s_nxt.tx     = {s_r.addr, s_r.rs, 1'b1};
          end
        endcase
      end
      H_BIT: if (adv) begin
        case (s_r.q)
          2'd0: s_nxt.sda_lo = !s_r.tx[8];
          2'd1: s_nxt.scl_lo = 1'b0;
          2'd2: s_nxt.rx = {s_r.rx[7:0], scl_q[1] ? sda_q[1] : 1'b1};
          default: begin
            s_nxt.scl_lo = 1'b1;
            s_nxt.tx     = {s_r.tx[7:0], 1'b1};
            s_nxt.bitn   = s_r.bitn + 1'b1;
            if (s_r.bitn == 4'd8) begin
              s_nxt.bitn = '0;
              if (s_r.seg != S_RD && s_r.rx[0]) begin
                s_nxt.nack = 1'b1;
                s_nxt.st   = H_STOP;
              end else begin
                case (s_r.seg)
                  S_AW: begin
                    s_nxt.seg = S_CMD;
                    s_nxt.tx  = {s_r.cmd, 1'b1};
                  end
                  S_CMD, S_WR: begin
                    if (s_r.seg == S_WR) begin
                      s_nxt.wl = s_r.wl - 1'b1;
                    end
                    if ((s_r.seg == S_CMD) ? (s_r.wl != 8'h00) : (s_r.wl > 8'h01)) begin
                      s_nxt.seg  = S_WR;  // [R6] [R14] [R15]
                      s_nxt.tx   = {wbyte_in, 1'b1};
                      s_nxt.take = 1'b1;
                    end else if (s_r.rl != 8'h00) begin
                      s_nxt.st = H_START;
                      s_nxt.rs = 1'b1;
                    end else begin
                      s_nxt.st = H_STOP;
                    end
                  end
                  S_AR: begin
                    s_nxt.seg = S_RD;
                    s_nxt.tx  = {8'hFF, s_r.rl == 8'h01};
                  end
                  default: begin
                    s_nxt.rv    = 1'b1;  // [R17]
                    s_nxt.rbyte = s_r.rx[8:1];
                    s_nxt.rl    = s_r.rl - 1'b1;
                    s_nxt.tx    = {8'hFF, s_r.rl == 8'h02};
                    if (s_r.rl == 8'h01) begin
                      s_nxt.st = H_STOP;
                    end
                  end
                endcase
              end
            end
          end
        endcase
      end
      H_STOP: if (adv) begin
        case (s_r.q)
          2'd0: s_nxt.sda_lo = 1'b1;
          2'd1: s_nxt.scl_lo = 1'b0;
          2'd2: s_nxt.sda_lo = 1'b0;
          default: s_nxt.st = H_GAP;
        endcase
      end
      H_GAP: begin
        s_nxt.gap = s_r.gap - 1'b1;
        if (s_r.gap <= GW'(1)) begin
          s_nxt.st   = H_IDLE;
          s_nxt.done = 1'b1;
        end
      end
      default: s_nxt.st = H_IDLE;
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bus.h_clk_out  = 1'b0;
  assign bus.h_dat_out  = 1'b0;
  assign bus.h_clk_oe_n = !s_r.scl_lo;
  assign bus.h_dat_oe_n = !s_r.sda_lo;
  assign req_ready_out  = (s_r.st == H_IDLE);
  assign wbyte_take_out = s_r.take;
  assign rbyte_out      = s_r.rbyte;
  assign rbyte_valid_out = s_r.rv;
  assign done_out       = s_r.done;
  assign nack_out       = s_r.nack;
endmodule : mgmt_host

// [supply_smbus_slave_port_checker.sv]
// Purpose: Wire checks on the pair joining host end and supply end
// Assumes: One clock domain; lines sampled on mclk_in
// Notes:   Timeout check only bites where a host parks the clock low
`timescale 1ns/1ps
module supply_smbus_slave_port_checker
  import smbus_pkg::*;
#(
  parameter int LOW_TMO = LOW_TMO_CYC
) (
  // Clock, reset and bus signals
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic bus_clk,
  input wire logic bus_dat,
  input wire logic h_clk_oe_n,
  input wire logic h_dat_oe_n,
  input wire logic d_clk_oe_n,
  input wire logic d_dat_oe_n
);
  logic [16:0] scnt_r, scnt_nxt;
  logic [15:0] fcnt_r, fcnt_nxt;
  int          tcnt_r, tcnt_nxt;
  logic        clk_r, clk_nxt, dat_r, dat_nxt, start_c, stop_c;

  always_comb begin
    clk_nxt  = bus_clk;
    dat_nxt  = bus_dat;
    start_c  = clk_r && bus_clk && dat_r && !bus_dat;
    stop_c   = clk_r && bus_clk && !dat_r && bus_dat;
    scnt_nxt = d_clk_oe_n ? 17'h0 : scnt_r + 17'h1;
    tcnt_nxt = bus_clk ? 0 : tcnt_r + 1;
    // Saturate so a long idle bus never wraps to a small gap
    fcnt_nxt = stop_c ? 16'h0 : ((fcnt_r == 16'hFFFF) ? fcnt_r : fcnt_r + 16'h1);
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      clk_r  <= 1'b1;
      dat_r  <= 1'b1;
      scnt_r <= 17'h0;
      fcnt_r <= 16'h0;
      tcnt_r <= 0;
    end else begin
      clk_r  <= clk_nxt;
      dat_r  <= dat_nxt;
      scnt_r <= scnt_nxt;
      fcnt_r <= fcnt_nxt;
      tcnt_r <= tcnt_nxt;
    end
  end

  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  a_no_dev_start: assert property ($fell(d_dat_oe_n) |-> !bus_clk)
    else $error("supply pulled data while clock high");
  a_no_dev_stop: assert property ($rose(d_dat_oe_n) |-> !bus_clk)
    else $error("supply released data while clock high");
  a_dev_clk_low: assert property ($fell(d_clk_oe_n) |-> !$past(bus_clk))
    else $error("supply began a clock low phase itself");
  a_stretch_max: assert property (!d_clk_oe_n |-> scnt_r < STRETCH_MAX_CYC)
    else $error("clock stretch too long");
  a_dat_steady: assert property ($rose(bus_clk) |=> $stable(d_dat_oe_n) [*8])
    else $error("supply data moved in clock high");
  a_tmo_release: assert property (tcnt_r == LOW_TMO + 8 |-> d_clk_oe_n && d_dat_oe_n)
    else $error("supply kept lines after low timeout");
  a_start_gap: assert property (start_c |-> fcnt_r >= BUF_CYC)
    else $error("start too soon after stop");
  a_rst_idle: assert property ($rose(rst_n_in) |-> d_clk_oe_n && d_dat_oe_n && h_clk_oe_n && h_dat_oe_n)
    else $error("lines not released after reset");

  c_stretch: cover property ($fell(d_clk_oe_n));
  c_ack: cover property ($fell(d_dat_oe_n));
  c_start: cover property (start_c);
endmodule : supply_smbus_slave_port_checker

// [supply_smbus_slave_port_tb_top.sv]
// Purpose: Bench for host and supply ends, plus a bench-driven second pair
// Assumes: Second pair is bit-banged fast to reach fault and boundary cases
// Notes:   Counts shortened by parameters; long block reads left out for run time
`timescale 1ns/1ps
module supply_smbus_slave_port_tb_top;
  import smbus_pkg::*;
  localparam int TMO = 2000;
  logic       mclk_in, rst_n_in = 1'b0, wp_in = 1'b0, wp2 = 1'b0, req_valid = 1'b0;
  logic       a, rdy, done, nack, rv, cs1, ws1, en1, rq1, cs2, ws2, en2, rq2;
  logic [6:0] ra7 = 7'h0;
  logic [7:0] rc = 8'h0, rwl = 8'h0, rrl = 8'h0, wb = 8'h0, rd1 = 8'h0, rd2 = 8'h0;
  logic [7:0] rb, c1, w1, n1, i1, c2, w2, n2, i2, v, got;
  logic [7:0] evq[$];
  int         fail_count, checks, seed;

  smbus_if u_smbus_if();
  smbus_if u_smbus_if2();
  mgmt_host #(.WR_GAP(300)) u_mgmt_host (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .bus(u_smbus_if.host), .req_valid_in(req_valid), .req_ready_out(rdy),
    .req_addr7_in(ra7), .req_cmd_in(rc), .req_wlen_in(rwl), .req_rlen_in(rrl),
    .wbyte_in(wb), .wbyte_take_out(), .rbyte_out(rb), .rbyte_valid_out(rv),
    .done_out(done), .nack_out(nack));
  supply_port #(.LOW_TMO(TMO), .WR_BUSY(300)) u_supply_port (.mclk_in(mclk_in),
    .rst_n_in(rst_n_in), .bus(u_smbus_if.dev), .wp_in(wp_in), .cmd_out(c1),
    .cmd_stb_out(cs1), .wdata_out(w1), .wdata_stb_out(ws1), .wcnt_out(n1),
    .xfer_end_out(en1), .rd_req_out(rq1), .rd_idx_out(i1), .rdata_in(rd1));
  supply_port #(.LOW_TMO(TMO), .WR_BUSY(300)) u_supply_port2 (.mclk_in(mclk_in),
    .rst_n_in(rst_n_in), .bus(u_smbus_if2.dev), .wp_in(wp2), .cmd_out(c2),
    .cmd_stb_out(cs2), .wdata_out(w2), .wdata_stb_out(ws2), .wcnt_out(n2),
    .xfer_end_out(en2), .rd_req_out(rq2), .rd_idx_out(i2), .rdata_in(rd2));
  supply_smbus_slave_port_checker #(.LOW_TMO(TMO)) u_checker (.mclk_in(mclk_in),
    .rst_n_in(rst_n_in), .bus_clk(u_smbus_if.bus_clk), .bus_dat(u_smbus_if.bus_dat),
    .h_clk_oe_n(u_smbus_if.h_clk_oe_n), .h_dat_oe_n(u_smbus_if.h_dat_oe_n),
    .d_clk_oe_n(u_smbus_if.d_clk_oe_n), .d_dat_oe_n(u_smbus_if.d_dat_oe_n));

  function automatic logic [7:0] rd_val(input logic [7:0] i);
    return 8'hC3 ^ {i[3:0], i[7:4]};
  endfunction : rd_val

  task automatic chk(input string nm, input logic [7:0] e, g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic tally_and_finish();
    if (fail_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  // Controller events of the second port, read data served on request
  always @(negedge mclk_in) begin
    if (cs2) evq.push_back(c2);
    if (ws2) evq.push_back(w2);
    if (en2) evq.push_back(n2);
    if (rq2) rd2 = rd_val(i2);
    if (rq1) rd1 = rd_val(i1);
    if (rv) got = rb;
    if (rst_n_in && cs1 !== 1'b0) chk("ctrl strobe", 8'h0, 8'h1);
  end

  task automatic q(input int n);
    repeat (n) @(negedge mclk_in);
  endtask : q

  // Enable value equals wanted level: 1 releases, 0 pulls low
  task automatic ln(input logic c, input logic d);
    u_smbus_if2.h_clk_oe_n = c;
    u_smbus_if2.h_dat_oe_n = d;
    q(5);
  endtask : ln

  task automatic sta();
    ln(1'b0, 1'b1);
    ln(1'b1, 1'b1);
    ln(1'b1, 1'b0);
    ln(1'b0, 1'b0);
  endtask : sta

  task automatic stp();
    ln(1'b0, 1'b0);
    ln(1'b1, 1'b0);
    ln(1'b1, 1'b1);
  endtask : stp

  task automatic bt(input logic b, output logic r);
    ln(1'b0, b);
    ln(1'b1, b);
    // Honour stretching, bounded; then stay high long enough to be seen
    for (int k = 0; k < 40 && u_smbus_if2.bus_clk !== 1'b1; k++) q(1);
    if (u_smbus_if2.bus_clk !== 1'b1) chk("clk free", 8'h1, 8'h0);
    q(3);
    r = u_smbus_if2.bus_dat;
    ln(1'b0, b);
  endtask : bt

  task automatic tx(input logic [7:0] d, input logic e);
    logic r;
    for (int k = 7; k >= 0; k--) bt(d[k], r);
    bt(1'b1, r);
    chk("ack", {7'h0, e}, {7'h0, !r});
  endtask : tx

  task automatic rx(input logic last, input logic [7:0] e);
    logic [7:0] d;
    logic       r;
    for (int k = 7; k >= 0; k--) bt(1'b1, d[k]);
    bt(last, r);
    chk("read byte", e, d);
  endtask : rx

  task automatic cw(input logic [7:0] c, input int n);
    logic [7:0] d[$];
    evq = {};
    sta();
    tx(8'h20, 1'b1);
    tx(c, 1'b1);
    for (int j = 0; j < n; j++) begin
      d.push_back(8'($random(seed)));
      tx(d[j], j < BLOCK_MAX);
    end
    stp();
    q(4);
    chk("command", c, evq.pop_front());
    for (int j = 0; j < n && j < BLOCK_MAX; j++) chk("data", d[j], evq.pop_front());
    chk("count", (n > BLOCK_MAX) ? 8'hFF : 8'(n), evq.pop_front());
  endtask : cw

  task automatic cr(input logic [7:0] c, input int n);
    sta();
    tx(8'h20, 1'b1);
    tx(c, 1'b1);
    sta();
    tx(8'h21, 1'b1);
    for (int j = 0; j < n; j++) rx(j == n - 1, rd_val(8'(j)));
    stp();
  endtask : cr

  task automatic st(input logic [7:0] l, d, input logic wr, ok);
    sta();
    tx(8'hA0, 1'b1);
    tx(l, 1'b1);
    if (wr) tx(d, ok);
    else begin
      sta();
      tx(8'hA1, 1'b1);
      rx(1'b1, d);
    end
    stp();
  endtask : st

  task automatic host_req(input logic [6:0] ad, input logic [7:0] c, wl, rl);
    ra7 = ad;
    rc = c;
    rwl = wl;
    rrl = rl;
    req_valid = 1'b1;
    for (int k = 0; k < 8 && rdy !== 1'b1; k++) q(1);
    @(posedge mclk_in);
    @(negedge mclk_in);
    req_valid = 1'b0;
    for (int k = 0; k < 60000 && done !== 1'b1; k++) q(1);
    if (done !== 1'b1) chk("done", 8'h1, 8'h0);
  endtask : host_req

  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end

  initial begin
    #950_000;
    fail_count++;
    tally_and_finish();
  end

  initial begin
    seed = 53;
    u_smbus_if2.h_clk_out = 1'b0;
    u_smbus_if2.h_dat_out = 1'b0;
    u_smbus_if2.h_clk_oe_n = 1'b1;
    u_smbus_if2.h_dat_oe_n = 1'b1;
    repeat (16) @(negedge mclk_in);
    rst_n_in = 1'b1;
    q(2);
    wb = 8'($random(seed));
    fork
      begin
        host_req(STORE_ADDR7, 8'h3C, 8'h1, 8'h0);
        chk("host nack", 8'h0, {7'h0, nack});
        host_req(STORE_ADDR7, 8'h3C, 8'h0, 8'h1);
        chk("host nack", 8'h0, {7'h0, nack});
        chk("host read", wb, got);
      end
      begin
        evq = {};
        sta();
        tx(8'h20, 1'b1);
        for (int k = 0; k < 3; k++) bt(k[0], a);
        stp();
        q(4);
        chk("stop end", 8'h1, 8'(evq.size()));
        evq = {};
        sta();
        v = 8'h20;
        for (int k = 7; k >= 0; k--) bt(v[k], a);
        ln(1'b0, 1'b1);
        q(TMO + 20);
        chk("free line", 8'h1, {7'h0, u_smbus_if2.bus_dat});
        chk("tmo end", 8'h1, 8'(evq.size()));
        ln(1'b1, 1'b1);
        for (int n = 0; n < 3; n++) cw(8'($random(seed)), n);
        cw(8'($random(seed)), 256);
        cr(8'($random(seed)), 2);
        cr(8'($random(seed)), 5);
        evq = {};
        v = 8'($random(seed));
        st(8'h7F, v, 1'b1, 1'b1);
        sta();
        tx(8'hA0, 1'b0);
        stp();
        q(300);
        st(8'h7F, v, 1'b0, 1'b0);
        wp2 = 1'b1;
        q(4);
        st(8'h7F, ~v, 1'b1, 1'b0);
        q(300);
        st(8'h7F, v, 1'b0, 1'b0);
        sta();
        tx(8'h30, 1'b0);
        stp();
        chk("ctrl events", 8'h0, 8'(evq.size()));
      end
    join
    tally_and_finish();
  end
endmodule : supply_smbus_slave_port_tb_top
